// >>> src/dbg_link_core.sv
// Instruction engine of the one-wire debug port data link
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Indirect load reads data space at the pointer, returns it serially.
// - Indirect load with pointer selection returns the pointer itself.
// - Address operands up to 24 bits, data operands up to 16 bits supported.
// - Indirect load reply starts only after turnaround idle bits.
// - Acknowledge after every completed indirect store.
// - Pointer code 2 store takes address bytes, writes pointer, acks.
// - Code 0 writes at pointer; code 1 also advances pointer by width.
// - Store takes exactly data-width bytes, acks after bus write.
// - Link register load reads one internal byte, never data space.
// - Link register reply byte follows turnaround idle period.
// - Link register store writes byte, sends no response.
// - Repeat loads count; next instruction runs count plus one times, except a link register store, which runs once.
// - Repeat count width taken from data-size field.
// - Repeated iterations reuse stored instruction, only operands sent.
// - Repeat instruction itself is never treated as repeatable.
// - Only a break ends an ongoing repeat.
// - Opcode decode of the three upper instruction bits.
// - Address and data width field decode, reserved codes flagged for indirect load and store only.
// - Error state ignores everything until a break.
// - Turnaround idle bits inserted before first reply byte.
module dbg_link_core
  import dbg_link_pkg::*;
#(
  parameter logic [7:0] ACK_CHAR = dbg_link_pkg::ACK_DEFAULT,
  parameter int         AW       = 32
)(
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          rx_valid_i,
  input  wire logic [7:0]    rx_data_i,
  input  wire logic          break_i,
  input  wire logic          tx_ready_i,
  output logic               tx_valid_o,
  output logic [7:0]         tx_data_o,
  output logic               tx_first_o,
  input  wire logic [2:0]    turnaround_bits_setting_i,
  output logic [2:0]         turnaround_idle_o,
  output logic               bus_req_o,
  output logic               bus_we_o,
  output logic [AW-1:0]      bus_addr_o,
  output logic [7:0]         bus_wdata_o,
  input  wire logic          bus_ack_i,
  input  wire logic [7:0]    bus_rdata_i,
  output logic               regs_we_o,
  output logic [3:0]         regs_addr_o,
  output logic [7:0]         regs_wdata_o,
  input  wire logic [7:0]    regs_rdata_i,
  output logic               error_o,
  output logic               repeat_active_o
);
  import dbg_link_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_OPER  = 3'b001,
    S_BUS   = 3'b010,
    S_SEND  = 3'b011,
    S_ERROR = 3'b100
  } state_t;

  state_t        state_q;
  logic [7:0]    instr_q;
  logic [AW-1:0] ptr_q;
  logic [7:0]    rpt_q;
  logic          rpt_on_q;
  logic [31:0]   shreg_q;
  logic [2:0]    cnt_q;
  logic [2:0]    len_q;
  logic [2:0]    bcnt_q;
  logic          first_q;

  logic [2:0] opc;
  logic [1:0] ptr_mode;
  logic [1:0] size_a;
  logic [1:0] size_b;
  logic [2:0] len_a;
  logic [2:0] len_b;
  logic       bad_size;
  logic       done_iter;
  logic [31:0] addr_asm;

  // incoming address byte lands at its own position
  always_comb
  begin
    addr_asm = shreg_q;
    addr_asm[8*cnt_q[1:0] +: 8] = rx_data_i;
  end

  // Decode of opcode and size fields
  // opcode field split
  assign opc      = instr_q[OP_MSB:OP_LSB];
  assign ptr_mode = instr_q[PTR_MSB:PTR_LSB];
  assign size_a   = instr_q[SZA_MSB:SZA_LSB];
  assign size_b   = instr_q[SZB_MSB:SZB_LSB];
  assign len_a    = (size_a == 2'h0) ? 3'd1 : (size_a == 2'h1) ? 3'd2 : 3'd3;
  assign len_b    = (size_b == 2'h0) ? 3'd1 : 3'd2;
  assign bad_size = size_b[1];

  // iteration done; zero count gives one run
  assign done_iter = (rpt_q == RPT_RESET);

  // Main sequencer; ack, bus, link registers and pointer all live here
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q      <= S_IDLE;
      instr_q      <= 8'h00;
      ptr_q        <= '0;
      rpt_q        <= RPT_RESET;
      rpt_on_q     <= 1'b0;
      shreg_q      <= 32'h0;
      cnt_q        <= 3'd0;
      len_q        <= 3'd0;
      bcnt_q       <= 3'd0;
      first_q      <= 1'b0;
      tx_valid_o   <= 1'b0;
      tx_data_o    <= 8'h00;
      tx_first_o   <= 1'b0;
      bus_req_o    <= 1'b0;
      bus_we_o     <= 1'b0;
      bus_addr_o   <= '0;
      bus_wdata_o  <= 8'h00;
      regs_we_o    <= 1'b0;
      regs_addr_o  <= 4'h0;
      regs_wdata_o <= 8'h00;
      error_o      <= 1'b0;
    end
    else
    begin
      regs_we_o <= 1'b0;
      // break is the only way out of repeat before its count runs out
      if (break_i)
      begin
        state_q    <= S_IDLE;
        rpt_on_q   <= 1'b0;
        rpt_q      <= RPT_RESET;
        tx_valid_o <= 1'b0;
        bus_req_o  <= 1'b0;
        error_o    <= 1'b0;
      end
      else
      begin
        case (state_q)
          S_IDLE:
          begin
            if (rx_valid_i)
            begin
              instr_q <= rx_data_i;
              cnt_q   <= 3'd0;
              bcnt_q  <= 3'd0;
              shreg_q <= 32'h0;
              first_q <= 1'b1;
              state_q <= S_OPER;
              // link register read address from the instruction
              if (rx_data_i[OP_MSB:OP_LSB] == OP_READ_REGS)
                regs_addr_o <= rx_data_i[CSA_MSB:CSA_LSB];
              // Indirect load has no operand bytes and goes straight out
              if (rx_data_i[OP_MSB:OP_LSB] == OP_LOAD_IND)
              begin
                if (rx_data_i[SZB_MSB] ||
                    rx_data_i[PTR_MSB:PTR_LSB] == SIZE_RSVD)
                begin
                  state_q <= S_ERROR;
                  error_o <= 1'b1;
                end
                else if (rx_data_i[PTR_MSB:PTR_LSB] == PTR_SELF)
                begin
                  shreg_q <= 32'(ptr_q);
                  len_q   <= 3'd4;
                  state_q <= S_SEND;
                end
                else
                begin
                  bus_req_o  <= 1'b1;
                  bus_we_o   <= 1'b0;
                  bus_addr_o <= ptr_q;
                  len_q      <= rx_data_i[SZB_LSB] ? 3'd2 : 3'd1;
                  state_q    <= S_BUS;
                end
              end
            end
          end
          S_OPER:
          begin
            if (rx_valid_i)
            begin
              case (opc)
                OP_WRITE_REGS:
                begin
                  regs_we_o    <= 1'b1;
                  regs_addr_o  <= instr_q[CSA_MSB:CSA_LSB];
                  regs_wdata_o <= rx_data_i;
                  state_q      <= S_IDLE;
                end
                OP_REPEAT:
                begin
                  // count of data-size width, low byte kept
                  cnt_q <= cnt_q + 3'd1;
                  if (cnt_q == 3'd0)
                    rpt_q <= rx_data_i;
                  if (cnt_q + 3'd1 == len_b)
                  begin
                    rpt_on_q <= 1'b1;
                    state_q  <= S_IDLE;
                  end
                end
                OP_WRITE_IND:
                begin
                  if (ptr_mode == PTR_SELF)
                  begin
                    // address bytes, low first, then ack
                    shreg_q[8*cnt_q +: 8] <= rx_data_i;
                    cnt_q <= cnt_q + 3'd1;
                    if (cnt_q + 3'd1 == len_a)
                    begin
                      ptr_q     <= AW'(addr_asm &
                                   ((32'h1 << (8*len_a)) - 32'h1));
                      tx_data_o <= ACK_CHAR;
                      len_q     <= 3'd0;
                      state_q   <= S_SEND;
                      tx_first_o <= 1'b1;
                      tx_valid_o <= 1'b1;
                    end
                  end
                  else
                  begin
                    // one bus write per data byte
                    bus_req_o   <= 1'b1;
                    bus_we_o    <= 1'b1;
                    bus_addr_o  <= ptr_q + AW'(cnt_q);
                    bus_wdata_o <= rx_data_i;
                    cnt_q       <= cnt_q + 3'd1;
                    state_q     <= S_BUS;
                  end
                end
                default:
                begin
                  // Direct and key forms are unsupported and enter the error state
                  state_q <= S_ERROR;
                  error_o <= 1'b1;
                end
              endcase
            end
            else if (opc == OP_READ_REGS)
            begin
              // internal byte only, never the system bus
              shreg_q <= {24'h0, regs_rdata_i};
              len_q   <= 3'd1;
              state_q <= S_SEND;
            end
            else if (opc == OP_WRITE_IND &&
                     (ptr_mode == SIZE_RSVD ||
                      (ptr_mode != PTR_SELF && bad_size) ||
                      (ptr_mode == PTR_SELF && size_a == SIZE_RSVD)))
            begin
              state_q <= S_ERROR;
              error_o <= 1'b1;
            end
          end
          S_BUS:
          begin
            if (bus_ack_i)
            begin
              bus_req_o <= 1'b0;
              if (bus_we_o)
              begin
                if (cnt_q == len_b)
                begin
                  if (ptr_mode == PTR_AT_INC)
                    ptr_q <= ptr_q + AW'(len_b);
                  tx_data_o  <= ACK_CHAR;
                  // line turned again, so each ack gets idle bits
                  tx_first_o <= 1'b1;
                  tx_valid_o <= 1'b1;
                  len_q      <= 3'd0;
                  state_q    <= S_SEND;
                end
                else
                  state_q <= S_OPER;
              end
              else
              begin
                shreg_q[8*bcnt_q +: 8] <= bus_rdata_i;
                bcnt_q <= bcnt_q + 3'd1;
                if (bcnt_q + 3'd1 == len_q)
                begin
                  bcnt_q  <= 3'd0;
                  state_q <= S_SEND;
                end
                else
                begin
                  bus_req_o  <= 1'b1;
                  bus_addr_o <= ptr_q + AW'(bcnt_q + 3'd1);
                end
              end
            end
          end
          S_SEND:
          begin
            if (!tx_valid_o && len_q != 3'd0)
            begin
              // first byte marked so the line inserts idle bits
              tx_data_o  <= shreg_q[8*bcnt_q +: 8];
              tx_first_o <= first_q;
              tx_valid_o <= 1'b1;
            end
            else if (tx_valid_o && tx_ready_i)
            begin
              tx_valid_o <= 1'b0;
              first_q    <= 1'b0;
              if (len_q != 3'd0 && bcnt_q + 3'd1 != len_q)
                bcnt_q <= bcnt_q + 3'd1;
              else
              begin
                bcnt_q <= 3'd0;
                cnt_q  <= 3'd0;
                // reuse stored instruction on later runs
                if (rpt_on_q && !done_iter && opc != OP_REPEAT)
                begin
                  rpt_q <= rpt_q - 8'h01;
                  if (opc == OP_LOAD_IND && ptr_mode != PTR_SELF)
                  begin
                    if (ptr_mode == PTR_AT_INC)
                      ptr_q <= ptr_q + AW'(len_b);
                    bus_req_o  <= 1'b1;
                    bus_we_o   <= 1'b0;
                    bus_addr_o <= (ptr_mode == PTR_AT_INC) ?
                                  ptr_q + AW'(len_b) : ptr_q;
                    state_q    <= S_BUS;
                  end
                  else if (opc == OP_LOAD_IND)
                    state_q <= S_SEND;
                  else
                    state_q <= S_OPER;
                end
                else
                begin
                  if (opc == OP_LOAD_IND && ptr_mode == PTR_AT_INC)
                    ptr_q <= ptr_q + AW'(len_b);
                  rpt_on_q <= 1'b0;
                  state_q  <= S_IDLE;
                end
              end
            end
          end
          S_ERROR:
          begin
            state_q <= S_ERROR;
          end
          default:
            state_q <= S_IDLE;
        endcase
      end
    end
  end

  // Turnaround bits exported registered for the line driver
  // idle bits count before first reply byte
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      turnaround_idle_o <= 3'd0;
    else
      turnaround_idle_o <= turnaround_bits_setting_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      repeat_active_o <= 1'b0;
    else
      repeat_active_o <= rpt_on_q;
  end

  // error state holds the error flag
  err_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_q == S_ERROR && !break_i) |=> error_o)
    else $error("error flag lost in error state");

  brk_rpt_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    break_i |=> !rpt_on_q && state_q == S_IDLE)
    else $error("break did not end repeat");

  // link register store gives no reply
  regs_norsp_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    regs_we_o |-> !tx_valid_o)
    else $error("reply after link register store");

  // link register reads stay off the bus
  regs_nobus_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (opc == OP_READ_REGS && state_q != S_IDLE) |-> !bus_req_o)
    else $error("link register read reached bus");

  // store completion sends ack next cycle
  store_ack_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_q == S_BUS && bus_ack_i && bus_we_o && cnt_q == len_b &&
     !break_i) |=> tx_valid_o && tx_data_o == ACK_CHAR)
    else $error("missing ack after store");

  post_inc_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_q == S_BUS && bus_ack_i && bus_we_o && cnt_q == len_b &&
     ptr_mode == PTR_AT_INC && !break_i)
    |=> ptr_q == $past(ptr_q) + AW'($past(len_b)))
    else $error("pointer not advanced");

  // pointer load replies with pointer bytes
  ptr_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_q == S_IDLE && rx_valid_i && !break_i &&
     rx_data_i[OP_MSB:OP_LSB] == OP_LOAD_IND &&
     rx_data_i[PTR_MSB:PTR_LSB] == PTR_SELF && !rx_data_i[SZB_MSB])
    |=> state_q == S_SEND && shreg_q == 32'($past(ptr_q)))
    else $error("pointer read wrong");

  // Line direction helper: a byte came in since the last one went out
  logic line_turned_q;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      line_turned_q <= 1'b0;
    else if (break_i || (tx_valid_o && tx_ready_i))
      line_turned_q <= 1'b0;
    else if (rx_valid_i && (state_q == S_IDLE || state_q == S_OPER))
      line_turned_q <= 1'b1;
  end

  // first reply byte flagged for turnaround
  first_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(tx_valid_o) && line_turned_q |-> tx_first_o)
    else $error("first reply not flagged");

  // no idle bits inside a continuous reply stream
  cont_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(tx_valid_o) && !line_turned_q |-> !tx_first_o)
    else $error("turnaround flagged inside reply stream");
endmodule
`default_nettype wire

// >>> include/dbg_link_pkg.sv
// Constants for the debug link instruction engine
package dbg_link_pkg;
  localparam logic [2:0] OP_LOAD_DIRECT  = 3'h0;
  localparam logic [2:0] OP_LOAD_IND     = 3'h1;
  localparam logic [2:0] OP_WRITE_DIRECT = 3'h2;
  localparam logic [2:0] OP_WRITE_IND    = 3'h3;
  localparam logic [2:0] OP_READ_REGS    = 3'h4;
  localparam logic [2:0] OP_REPEAT       = 3'h5;
  localparam logic [2:0] OP_WRITE_REGS   = 3'h6;
  localparam logic [2:0] OP_KEY          = 3'h7;
  localparam logic [1:0] PTR_AT          = 2'h0;
  localparam logic [1:0] PTR_AT_INC      = 2'h1;
  localparam logic [1:0] PTR_SELF        = 2'h2;
  localparam logic [1:0] SIZE_RSVD       = 2'h3;
  localparam int OP_MSB   = 7;
  localparam int OP_LSB   = 5;
  localparam int PTR_MSB  = 3;
  localparam int PTR_LSB  = 2;
  localparam int SZA_MSB  = 1;
  localparam int SZA_LSB  = 0;
  localparam int SZB_MSB  = 1;
  localparam int SZB_LSB  = 0;
  localparam int CSA_MSB  = 3;
  localparam int CSA_LSB  = 0;
  localparam logic [7:0]  ACK_DEFAULT  = 8'h40;
  localparam logic [31:0] PTR_RESET    = 32'h0000_0000;
  localparam logic [7:0]  RPT_RESET    = 8'h00;
endpackage

// >>> verif/data_space_model.sv
// Data space and link register responder facing the instruction engine
`timescale 1ns/1ps
`default_nettype none
module data_space_model #(
  parameter int AW = 32
)(
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          slow_i,
  input  wire logic          bus_req_i,
  input  wire logic          bus_we_i,
  input  wire logic [AW-1:0] bus_addr_i,
  input  wire logic [7:0]    bus_wdata_i,
  output logic               bus_ack_o,
  output logic [7:0]         bus_rdata_o,
  input  wire logic          regs_we_i,
  input  wire logic [3:0]    regs_addr_i,
  input  wire logic [7:0]    regs_wdata_i,
  input  wire logic [3:0]    rd_addr_i,
  output logic [7:0]         regs_rdata_o
);
  logic [7:0] mem [256];
  logic [7:0] regs [16];
  logic [2:0] wait_q;
  int         n_req;

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'h00;
    for (int i = 0; i < 16; i++)
      regs[i] = 8'h00;
  end

  // Slow mode stretches each access so the engine must stall
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bus_ack_o   <= 1'b0;
      bus_rdata_o <= 8'h5a;
      wait_q      <= 3'h0;
      n_req       <= 0;
    end
    else if (bus_req_i && !bus_ack_o && wait_q >= (slow_i ? 3'h5 : 3'h0))
    begin
      bus_ack_o <= 1'b1;
      wait_q    <= 3'h0;
      n_req     <= n_req + 1;
      if (bus_we_i)
        mem[bus_addr_i[7:0]] <= bus_wdata_i;
      else
        bus_rdata_o <= mem[bus_addr_i[7:0]];
    end
    else
    begin
      // Read data is only valid with ack; toggle it otherwise
      bus_ack_o   <= 1'b0;
      bus_rdata_o <= ~bus_rdata_o;
      if (bus_req_i && !bus_ack_o)
        wait_q <= wait_q + 3'h1;
    end
  end

  always @(posedge clk_i)
  begin
    if (regs_we_i)
      regs[regs_addr_i] <= regs_wdata_i;
  end

  assign regs_rdata_o = regs[rd_addr_i];
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the debug link instruction engine
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dbg_link_pkg::*;
  logic        clk, rst_n, rx_valid, brk, tx_ready, slow;
  logic        tx_valid, tx_first, bus_req, bus_we, bus_ack;
  logic        regs_we, err, rpt;
  logic [7:0]  rx_data, tx_data, bus_wdata, bus_rdata;
  logic [7:0]  regs_wdata, regs_rdata;
  logic [2:0]  gt_set, gt_idle;
  logic [3:0]  regs_addr;
  logic [31:0] bus_addr;
  int          n_errors, num_checks, cyc;
  logic [2:0]  bad_op [3] = '{OP_LOAD_DIRECT, OP_WRITE_DIRECT, OP_KEY};

  dbg_link_core #(.ACK_CHAR(ACK_DEFAULT), .AW(32)) dut (
    .clk_i(clk), .rst_n_i(rst_n), .rx_valid_i(rx_valid),
    .rx_data_i(rx_data), .break_i(brk), .tx_ready_i(tx_ready),
    .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_first_o(tx_first),
    .turnaround_bits_setting_i(gt_set), .turnaround_idle_o(gt_idle),
    .bus_req_o(bus_req), .bus_we_o(bus_we), .bus_addr_o(bus_addr),
    .bus_wdata_o(bus_wdata), .bus_ack_i(bus_ack),
    .bus_rdata_i(bus_rdata), .regs_we_o(regs_we),
    .regs_addr_o(regs_addr), .regs_wdata_o(regs_wdata),
    .regs_rdata_i(regs_rdata), .error_o(err), .repeat_active_o(rpt));

  data_space_model #(.AW(32)) far (
    .clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .bus_req_i(bus_req),
    .bus_we_i(bus_we), .bus_addr_i(bus_addr), .bus_wdata_i(bus_wdata),
    .bus_ack_o(bus_ack), .bus_rdata_o(bus_rdata), .regs_we_i(regs_we),
    .regs_addr_i(regs_addr), .regs_wdata_i(regs_wdata),
    .rd_addr_i(regs_addr), .regs_rdata_o(regs_rdata));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic wrap_up;
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard: the whole sequence needs under a thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  function automatic logic [7:0] ins(logic [2:0] op, logic [1:0] p,
                                     logic [1:0] sz);
    return {op, 1'b0, p, sz};
  endfunction

  // Byte gap mimics a serial frame time, longer than a slow bus access
  // sync is stripped by the UART; bench sends frames only
  task automatic send(input logic [7:0] b);
    rx_data  = b;
    rx_valid = 1'b1;
    tick(1);
    rx_valid = 1'b0;
    rx_data  = ~b;
    tick(9);
  endtask

  task automatic recv(input logic [7:0] e, input logic f);
    int k;
    k = 0;
    while (tx_valid !== 1'b1 && k < 200)
    begin
      tick(1);
      k++;
    end
    chk(tx_valid, 1'b1);
    chk(tx_data, e);
    chk(tx_first, f);
    tx_ready = 1'b1;
    tick(1);
    tx_ready = 1'b0;
    tick(1);
  endtask

  task automatic quiet(input int n);
    int bad;
    bad = 0;
    repeat (n)
    begin
      tick(1);
      if (tx_valid !== 1'b0)
        bad++;
    end
    chk(bad, 0);
  endtask

  task automatic brk_pulse;
    brk = 1'b1;
    tick(1);
    brk = 1'b0;
    tick(2);
  endtask

  task automatic set_ptr(input logic [23:0] a);
    send(ins(OP_WRITE_IND, PTR_SELF, 2'h2));
    send(a[7:0]);
    send(a[15:8]);
    send(a[23:16]);
    recv(ACK_DEFAULT, 1'b1);
  endtask

  task automatic chk_ptr(input logic [31:0] a);
    send(ins(OP_LOAD_IND, PTR_SELF, 2'h0));
    for (int i = 0; i < 4; i++)
      recv(a[8*i +: 8], i == 0);
  endtask

  task automatic rpt_cnt(input logic [7:0] n);
    send(ins(OP_REPEAT, 2'h0, 2'h0));
    send(n);
  endtask

  initial
  begin
    rst_n = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    brk = 1'b0;
    tx_ready = 1'b0;
    slow = 1'b0;
    gt_set = 3'h5;
    n_errors = 0;
    num_checks = 0;
    cyc = 0;
    tick(4);
    rst_n = 1'b1;
    chk({tx_valid, bus_req, err, rpt, regs_we}, 0);
    tick(2);
    chk(gt_idle, 3'h5);
    // Link register store then load, never touching data space
    send(ins(OP_WRITE_REGS, 2'h0, 2'h3));
    send(8'ha5);
    chk(far.regs[3], 8'ha5);
    quiet(20);
    send(ins(OP_READ_REGS, 2'h0, 2'h3));
    recv(8'ha5, 1'b1);
    send(ins(OP_WRITE_REGS, 2'h1, 2'h3));
    send(8'h3c);
    send(ins(OP_READ_REGS, 2'h1, 2'h3));
    recv(8'h3c, 1'b1);
    chk(far.n_req, 0);
    gt_set = 3'h2;
    tick(2);
    chk(gt_idle, 3'h2);
    set_ptr(24'h123456);
    chk_ptr(32'h0012_3456);
    send(ins(OP_WRITE_IND, PTR_SELF, 2'h0));
    send(8'h77);
    recv(ACK_DEFAULT, 1'b1);
    chk_ptr(32'h0000_0077);
    set_ptr(24'h000120);
    chk_ptr(32'h0000_0120);
    send(ins(OP_WRITE_IND, PTR_AT, 2'h0));
    send(8'h11);
    recv(ACK_DEFAULT, 1'b1);
    chk(far.mem[8'h20], 8'h11);
    chk_ptr(32'h0000_0120);
    slow = 1'b1;
    send(ins(OP_WRITE_IND, PTR_AT_INC, 2'h1));
    send(8'h22);
    send(8'h33);
    recv(ACK_DEFAULT, 1'b1);
    chk({far.mem[8'h21], far.mem[8'h20]}, 16'h3322);
    chk_ptr(32'h0000_0122);
    // Block write: stored instruction reused, data after each ack
    rpt_cnt(8'h02);
    send(ins(OP_WRITE_IND, PTR_AT_INC, 2'h0));
    for (int i = 0; i < 3; i++)
    begin
      send(8'ha0 + 8'(i));
      recv(ACK_DEFAULT, 1'b1);
      chk(far.mem[8'h22 + 8'(i)], 8'ha0 + 8'(i));
    end
    tick(2);
    chk(rpt, 1'b0);
    chk_ptr(32'h0000_0125);
    // Block read: turnaround only before the first byte
    slow = 1'b0;
    set_ptr(24'h000120);
    rpt_cnt(8'h03);
    send(ins(OP_LOAD_IND, PTR_AT_INC, 2'h0));
    recv(8'h22, 1'b1);
    recv(8'h33, 1'b0);
    recv(8'ha0, 1'b0);
    recv(8'ha1, 1'b0);
    rpt_cnt(8'h00);
    send(ins(OP_LOAD_IND, PTR_AT_INC, 2'h1));
    recv(8'ha2, 1'b1);
    recv(8'h00, 1'b0);
    quiet(10);
    chk(rpt, 1'b0);
    // Unsupported opcodes lock the engine until a break
    for (int i = 0; i < 3; i++)
    begin
      send(ins(bad_op[i], 2'h0, 2'h0));
      send(ins(OP_READ_REGS, 2'h0, 2'h3));
      chk(err, 1'b1);
      send(ins(OP_READ_REGS, 2'h0, 2'h3));
      quiet(10);
      brk_pulse();
      chk(err, 1'b0);
    end
    send(ins(OP_WRITE_IND, PTR_AT, 2'h2));
    chk(err, 1'b1);
    brk_pulse();
    send(ins(OP_READ_REGS, 2'h0, 2'h3));
    recv(8'ha5, 1'b1);
    // Only a break ends a repeat in progress
    set_ptr(24'h000140);
    rpt_cnt(8'h05);
    send(ins(OP_WRITE_IND, PTR_AT_INC, 2'h0));
    send(8'h77);
    recv(ACK_DEFAULT, 1'b1);
    chk(rpt, 1'b1);
    brk_pulse();
    chk(rpt, 1'b0);
    send(ins(OP_READ_REGS, 2'h0, 2'h3));
    recv(8'ha5, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
